// *** src/dac_vol_defines.svh ***
`ifndef DAC_VOL_DEFINES_SVH
`define DAC_VOL_DEFINES_SVH
// register indices; byte address is index times four
`define IDX_FLAGS      10'h026
`define IDX_STEP_CTRL  10'h03f
`define IDX_MUTE_CTRL  10'h040
`define IDX_GAIN       10'h041
`define IDX_DRC_CTRL   10'h044
`define IDX_PIN_CTRL   10'h074
`define IDX_PIN_GAIN   10'h075
`define IDX_RATE       10'h080
`define IDX_COEF_LO    10'h10e
`define IDX_COEF_HI    10'h119
// field positions
`define BIT_DONE       4
`define BIT_MUTE       3
`define BIT_MASTER     1
`define BIT_DRC_A      6
`define BIT_DRC_B      5
`define BIT_PIN_EN     7
`define BIT_PIN_CLK    6
// reset values
`define RST_MUTE_CTRL  8'h02
`define RST_GAIN       8'h00
`define RST_STEP       2'h0
`define RST_DRC        8'h00
`define RST_PIN        8'h00
`define RST_RATE       2'h0
`define COEF_RESET     96'h7fab_8055_7f56_0011_0011_7fde
// gain limits in eighth-decibel and half-decibel units
`define GAIN_MAX_HALF  8'h30
`define GAIN_MIN       11'h604
`define DRC_MAX        11'h030
`define DRC_MIN        11'h7a0
// volume pin code map
`define PIN_HALF_LAST  7'h5a
`define PIN_MUTE_CODE  7'h7f
`define PIN_TOP_HALF   8'h24
`define PIN_LOW_BASE   8'h7e
`define PIN_MUTE_HALF  8'h81
// compressor detector levels
`define PEAK_LEVEL     16'h4000
`define LOW_LEVEL      16'h0800
`endif

// *** src/dac_vol_pkg.sv ***
package dac_vol_pkg;
    typedef enum logic [2:0] {
        SAR_IDLE = 3'b001,
        SAR_CONV = 3'b010,
        SAR_WAIT = 3'b100
    } sar_state_e;
    typedef enum logic [1:0] {
        FILT_A = 2'h0,
        FILT_B = 2'h1,
        FILT_C = 2'h2
    } filter_e;
endpackage

// *** src/dac_volume_front.sv ***
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ns
`include "dac_vol_defines.svh"
// How it works
// - gain +24 to -63.5 dB, half-dB steps
// - mono gain setting from gain register
// - mute and master control bits
// - step 0.125 dB per sample toward target
// - step mode: normal, half rate, off
// - done flag when actual equals target, or whenever step mode is off
// - register source unless pin mode set
// - pin code overwrites gain setting
// - last pin gain readable
// - pin converter clock and update rate
// - pin code to gain map with mute
// - compressor enable bits
// - cut gain on peaks, raise when low
// - high-pass then low-pass estimator
// - six 16-bit estimator coefficients
// - filter A up to 48 ksps
// - filter B up to 96 ksps
// - filter C for 192 ksps
// - applied gain adds compressor output
module dac_volume_front #(
    parameter int SAR_DIV_INT = 50,
    parameter int SAR_DIV_EXT = 200,
    parameter int UPDATE_BASE = 8
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic        hwrite,
    input  wire logic [1:0]  htrans,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [15:0] sample_in,
    input  wire logic        sample_valid,
    output logic      [15:0] sample_out,
    output logic             sample_out_valid,
    input  wire logic        vol_cmp,
    output logic      [6:0]  sar_trial,
    output logic      [1:0]  interp_filter_sel,
    output logic      [15:0] energy_level
);

    // ---- functions
    // saturate a wide signed value to 16 bits
    function automatic logic [15:0] sat16(input logic signed [47:0] v);
        if (v > 48'sd32767) begin
            sat16 = 16'h7fff;
        end else if (v < -48'sd32768) begin
            sat16 = 16'h8000;
        end else begin
            sat16 = v[15:0];
        end
    endfunction

    // first-order section, coefficients scaled by 2^15
    function automatic logic [15:0] iir1(
        input logic signed [15:0] x,
        input logic signed [15:0] xp,
        input logic signed [15:0] yp,
        input logic signed [15:0] n0,
        input logic signed [15:0] n1,
        input logic signed [15:0] d1
    );
        logic signed [47:0] acc;
        acc = 48'(n0 * x) + 48'(n1 * xp) + 48'(d1 * yp);
        iir1 = sat16(acc >>> 15);
    endfunction

    // half-decibel mantissa over one 6 dB octave, Q2.14
    function automatic logic [15:0] mant(input logic [3:0] r);
        case (r)
            4'h0: mant = 16'h4000;
            4'h1: mant = 16'h43cb;
            4'h2: mant = 16'h47cf;
            4'h3: mant = 16'h4c11;
            4'h4: mant = 16'h5092;
            4'h5: mant = 16'h5558;
            4'h6: mant = 16'h5a66;
            4'h7: mant = 16'h5fc2;
            4'h8: mant = 16'h656f;
            4'h9: mant = 16'h6b71;
            4'ha: mant = 16'h71cf;
            default: mant = 16'h788d;
        endcase
    endfunction

    // multiply by a gain in eighth-decibel units
    function automatic logic [15:0] apply_gain(
        input logic signed [15:0] x,
        input logic signed [10:0] g
    );
        logic [9:0]         hp;
        logic signed [5:0]  sh;
        logic signed [47:0] p;
        hp = 10'(10'sd264 + 10'(g >>> 2));
        sh = 6'(hp / 10'd12) - 6'sd22;
        p = 48'(x * $signed({1'b0, mant(4'(hp % 10'd12))}));
        if (sh >= 0) begin
            p = p <<< sh;
        end else begin
            p = p >>> (-sh);
        end
        apply_gain = sat16(p >>> 14);
    endfunction

    // pin code to half-decibel setting
    function automatic logic [7:0] pin_map(input logic [6:0] c);
        if (c == `PIN_MUTE_CODE) begin
            pin_map = `PIN_MUTE_HALF;
        end else if (c <= `PIN_HALF_LAST) begin
            pin_map = `PIN_TOP_HALF - {1'b0, c};
        end else begin
            pin_map = `PIN_LOW_BASE - {c, 1'b0};
        end
    endfunction

    // ---- state
    logic [7:0]  coef [0:11];
    logic [7:0]  next_coef [0:11];
    logic [7:0]  gain_set, next_gain_set;
    logic [7:0]  mute_ctrl, next_mute_ctrl;
    logic [1:0]  step_mode, next_step_mode;
    logic [7:0]  drc_ctrl, next_drc_ctrl;
    logic [7:0]  pin_ctrl, next_pin_ctrl;
    logic [6:0]  pin_gain, next_pin_gain;
    logic [1:0]  rate, next_rate;
    logic        wr_pend, next_wr_pend;
    logic [9:0]  wr_idx, next_wr_idx;
    logic [31:0] next_hrdata, rd_word;
    logic [1:0]  next_filter;
    logic [10:0] actual, next_actual;
    logic [10:0] drc_off, next_drc_off;
    logic        phase, next_phase;
    logic [15:0] next_sample_out;
    logic        next_out_valid;
    logic [15:0] hp_x1, next_hp_x1, hp_y, next_hp_y;
    logic [15:0] lp_y, next_lp_y;
    logic [15:0] next_energy;
    logic        pin_mute, next_pin_mute;
    dac_vol_pkg::sar_state_e sar_st, next_sar_st;
    logic [6:0]  next_trial;
    logic [2:0]  bit_idx, next_bit_idx;
    logic [15:0] div_cnt, next_div_cnt;
    logic        tick, next_tick;
    logic [15:0] wait_cnt, next_wait_cnt;
    logic        sar_apply, next_sar_apply;
    logic [6:0]  sar_code, next_sar_code;

    // ---- decoded controls
    logic        addr_ok;
    logic        step_off;
    logic        drc_en;
    logic        pin_en;
    logic [10:0] target;
    logic        done;
    logic [7:0]  gain_clamp;
    logic [3:0]  cidx;

    assign addr_ok  = hsel & htrans[1] & hready;
    assign step_off = step_mode[1];
    assign drc_en   = drc_ctrl[`BIT_DRC_A] | drc_ctrl[`BIT_DRC_B];
    assign pin_en   = pin_ctrl[`BIT_PIN_EN];
    assign cidx     = 4'(wr_idx - `IDX_COEF_LO);

    // requested gain in eighth-decibel units
    always_comb begin
        if ($signed(gain_set) > $signed(`GAIN_MAX_HALF)) begin
            gain_clamp = `GAIN_MAX_HALF;
        end else begin
            gain_clamp = gain_set;
        end
        if (mute_ctrl[`BIT_MUTE] | pin_mute) begin
            target = `GAIN_MIN;
        end else if (mute_ctrl[`BIT_MASTER]) begin
            target = {{1{gain_clamp[7]}}, gain_clamp, 2'b00};
        end else begin
            target = 11'h000;
        end
        done = step_off | (actual == target);
    end

    // ---- register read mux
    always_comb begin
        rd_word = 32'h0;
        case (haddr[11:2])
            `IDX_FLAGS:     rd_word = 32'(done) << `BIT_DONE;
            `IDX_STEP_CTRL: rd_word = {30'h0, step_mode};
            `IDX_MUTE_CTRL: rd_word = {24'h0, mute_ctrl};
            `IDX_GAIN:      rd_word = {24'h0, gain_set};
            `IDX_DRC_CTRL:  rd_word = {24'h0, drc_ctrl};
            `IDX_PIN_CTRL:  rd_word = {24'h0, pin_ctrl};
            `IDX_PIN_GAIN:  rd_word = {25'h0, pin_gain};
            `IDX_RATE:      rd_word = {30'h0, rate};
            default: begin
                if (haddr[11:2] >= `IDX_COEF_LO && haddr[11:2] <= `IDX_COEF_HI) begin
                    rd_word = {24'h0, coef[4'(haddr[11:2] - `IDX_COEF_LO)]};
                end
            end
        endcase
    end

    // bus phases: read data latched in address phase
    always_comb begin
        next_wr_pend = addr_ok & hwrite;
        next_wr_idx  = addr_ok ? haddr[11:2] : wr_idx;
        next_hrdata  = (addr_ok & ~hwrite) ? rd_word : hrdata;
    end

    // register writes and pin overwrite
    always_comb begin
        next_coef      = coef;
        next_gain_set  = gain_set;
        next_mute_ctrl = mute_ctrl;
        next_step_mode = step_mode;
        next_drc_ctrl  = drc_ctrl;
        next_pin_ctrl  = pin_ctrl;
        next_pin_gain  = pin_gain;
        next_rate      = rate;
        next_pin_mute  = pin_mute & pin_en;
        if (wr_pend) begin
            case (wr_idx)
                `IDX_STEP_CTRL: next_step_mode = hwdata[1:0];
                `IDX_MUTE_CTRL: next_mute_ctrl = hwdata[7:0] & 8'h0a;
                `IDX_GAIN:      next_gain_set  = hwdata[7:0];
                `IDX_DRC_CTRL:  next_drc_ctrl  = hwdata[7:0];
                `IDX_PIN_CTRL:  next_pin_ctrl  = hwdata[7:0] & 8'hc7;
                `IDX_RATE:      next_rate      = hwdata[1:0];
                default: begin
                    if (wr_idx >= `IDX_COEF_LO && wr_idx <= `IDX_COEF_HI) begin
                        next_coef[cidx] = hwdata[7:0];
                    end
                end
            endcase
        end
        if (sar_apply & pin_en) begin
            next_gain_set = pin_map(sar_code);
            next_pin_gain = sar_code;
            next_pin_mute = (sar_code == `PIN_MUTE_CODE);
        end
    end

    // interpolation filter chosen from the rate mode
    always_comb begin
        case (rate)
            2'h0:    next_filter = dac_vol_pkg::FILT_A;
            2'h1:    next_filter = dac_vol_pkg::FILT_B;
            default: next_filter = dac_vol_pkg::FILT_C;
        endcase
    end

    // soft stepping, gain stage and compressor offset
    always_comb begin
        logic [15:0] hp_new;
        logic [15:0] lp_new;
        logic [15:0] mag;
        hp_new          = 16'h0;
        lp_new          = 16'h0;
        mag             = 16'h0;
        next_actual     = actual;
        next_phase      = phase;
        next_drc_off    = drc_en ? drc_off : 11'h000;
        next_sample_out = sample_out;
        next_out_valid  = sample_valid;
        next_hp_x1      = hp_x1;
        next_hp_y       = hp_y;
        next_lp_y       = lp_y;
        next_energy     = energy_level;
        if (sample_valid) begin
            next_phase = (step_mode == 2'h1) ? ~phase : 1'b0;
            if (step_off) begin
                next_actual = target;
            end else if (step_mode == 2'h0 || phase) begin
                if ($signed(actual) < $signed(target)) begin
                    next_actual = actual + 11'h001;
                end else if (actual != target) begin
                    next_actual = actual - 11'h001;
                end
            end
            if (next_actual == `GAIN_MIN && target == `GAIN_MIN) begin
                next_sample_out = 16'h0;
            end else begin
                next_sample_out = apply_gain(sample_in, 11'(next_actual + drc_off));
            end
        end
        if (sample_out_valid) begin
            hp_new = iir1(sample_out, hp_x1, hp_y,
                {coef[0], coef[1]}, {coef[2], coef[3]}, {coef[4], coef[5]});
            lp_new = iir1(hp_new, hp_y, lp_y,
                {coef[6], coef[7]}, {coef[8], coef[9]}, {coef[10], coef[11]});
            mag = lp_new[15] ? 16'(-lp_new) : lp_new;
            next_hp_x1  = sample_out;
            next_hp_y   = hp_new;
            next_lp_y   = lp_new;
            next_energy = mag;
            if (drc_en) begin
                if (mag > `PEAK_LEVEL && drc_off != `DRC_MIN) begin
                    next_drc_off = drc_off - 11'h001;
                end else if (mag < `LOW_LEVEL && drc_off != `DRC_MAX) begin
                    next_drc_off = drc_off + 11'h001;
                end
            end
        end
    end

    // converter tick divider and successive approximation
    always_comb begin
        logic [6:0]  t;
        logic [15:0] lim;
        t   = sar_trial;
        lim = 16'(SAR_DIV_INT - 1);
        if (pin_ctrl[`BIT_PIN_CLK]) begin
            lim = 16'(SAR_DIV_EXT - 1);
        end
        next_tick      = (div_cnt >= lim);
        next_div_cnt   = next_tick ? 16'h0 : div_cnt + 16'h1;
        next_sar_st    = sar_st;
        next_trial     = sar_trial;
        next_bit_idx   = bit_idx;
        next_wait_cnt  = wait_cnt;
        next_sar_apply = 1'b0;
        next_sar_code  = sar_code;
        case (sar_st)
            dac_vol_pkg::SAR_IDLE: begin
                if (pin_en) begin
                    next_sar_st  = dac_vol_pkg::SAR_CONV;
                    next_trial   = 7'h40;
                    next_bit_idx = 3'h6;
                end
            end
            dac_vol_pkg::SAR_CONV: begin
                if (tick) begin
                    if (!vol_cmp) begin
                        t[bit_idx] = 1'b0;
                    end
                    if (bit_idx == 3'h0) begin
                        next_sar_apply = 1'b1;
                        next_sar_code  = t;
                        next_wait_cnt  = 16'h0;
                        next_sar_st    = dac_vol_pkg::SAR_WAIT;
                    end else begin
                        t[bit_idx - 3'h1] = 1'b1;
                        next_bit_idx = bit_idx - 3'h1;
                    end
                    next_trial = t;
                end
            end
            dac_vol_pkg::SAR_WAIT: begin
                if (tick) begin
                    next_wait_cnt = wait_cnt + 16'h1;
                    if (wait_cnt >= 16'((UPDATE_BASE << pin_ctrl[2:0]) - 1)) begin
                        next_sar_st = dac_vol_pkg::SAR_IDLE;
                    end
                end
            end
            default: next_sar_st = dac_vol_pkg::SAR_IDLE;
        endcase
        if (!pin_en) begin
            next_sar_st = dac_vol_pkg::SAR_IDLE;
        end
    end

    // ---- registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 12; i++) begin
                coef[i] <= 8'(`COEF_RESET >> (88 - 8 * i));
            end
            gain_set          <= `RST_GAIN;
            mute_ctrl         <= `RST_MUTE_CTRL;
            step_mode         <= `RST_STEP;
            drc_ctrl          <= `RST_DRC;
            pin_ctrl          <= `RST_PIN;
            pin_gain          <= 7'h0;
            rate              <= `RST_RATE;
            wr_pend           <= 1'b0;
            wr_idx            <= 10'h0;
            hrdata            <= 32'h0;
            hreadyout         <= 1'b1;
            hresp             <= 1'b0;
            interp_filter_sel <= dac_vol_pkg::FILT_A;
            actual            <= 11'h000;
            drc_off           <= 11'h000;
            phase             <= 1'b0;
            sample_out        <= 16'h0;
            sample_out_valid  <= 1'b0;
            hp_x1             <= 16'h0;
            hp_y              <= 16'h0;
            lp_y              <= 16'h0;
            energy_level      <= 16'h0;
            pin_mute          <= 1'b0;
            sar_st            <= dac_vol_pkg::SAR_IDLE;
            sar_trial         <= 7'h0;
            bit_idx           <= 3'h0;
            div_cnt           <= 16'h0;
            tick              <= 1'b0;
            wait_cnt          <= 16'h0;
            sar_apply         <= 1'b0;
            sar_code          <= 7'h0;
        end else begin
            coef              <= next_coef;
            gain_set          <= next_gain_set;
            mute_ctrl         <= next_mute_ctrl;
            step_mode         <= next_step_mode;
            drc_ctrl          <= next_drc_ctrl;
            pin_ctrl          <= next_pin_ctrl;
            pin_gain          <= next_pin_gain;
            rate              <= next_rate;
            wr_pend           <= next_wr_pend;
            wr_idx            <= next_wr_idx;
            hrdata            <= next_hrdata;
            hreadyout         <= 1'b1;
            hresp             <= 1'b0;
            interp_filter_sel <= next_filter;
            actual            <= next_actual;
            drc_off           <= next_drc_off;
            phase             <= next_phase;
            sample_out        <= next_sample_out;
            sample_out_valid  <= next_out_valid;
            hp_x1             <= next_hp_x1;
            hp_y              <= next_hp_y;
            lp_y              <= next_lp_y;
            energy_level      <= next_energy;
            pin_mute          <= next_pin_mute;
            sar_st            <= next_sar_st;
            sar_trial         <= next_trial;
            bit_idx           <= next_bit_idx;
            div_cnt           <= next_div_cnt;
            tick              <= next_tick;
            wait_cnt          <= next_wait_cnt;
            sar_apply         <= next_sar_apply;
            sar_code          <= next_sar_code;
        end
    end

endmodule

// *** testbench/dac_volume_front_props.sv ***
`timescale 1ns/1ns
`include "dac_vol_defines.svh"
module dac_volume_front_props (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [11:0] haddr,
    input wire logic        hwrite,
    input wire logic [1:0]  htrans,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        sample_valid,
    input wire logic [15:0] sample_out,
    input wire logic        sample_out_valid,
    input wire logic [1:0]  interp_filter_sel,
    input wire logic [15:0] energy_level
);
    logic rate_dp;
    logic next_rate_dp;
    // data phase of a write to the rate register
    always_comb begin
        next_rate_dp = hsel && htrans[1] && hready && hwrite && (haddr[11:2] == `IDX_RATE);
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rate_dp <= 1'b0;
        end else begin
            rate_dp <= next_rate_dp;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // a sample is taken, its result follows
    sequence s_take;
        sample_valid;
    endsequence
    sequence s_answer;
        sample_out_valid;
    endsequence
    chk_answer_next: assert property (s_take |=> s_answer)
        else $error("sample result missing");
    chk_no_extra: assert property (!sample_valid |=> !sample_out_valid)
        else $error("result without sample");
    chk_out_holds: assert property (!sample_valid |=> $stable(sample_out))
        else $error("output moved between samples");
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready okay");
    chk_read_holds: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
        else $error("read data moved without read");
    chk_filter_legal: assert property (interp_filter_sel != 2'h3)
        else $error("filter code unused value");
    chk_filter_cause: assert property ($changed(interp_filter_sel) |-> $past(rate_dp) || $past(rate_dp, 2))
        else $error("filter changed without rate write");
    chk_energy_time: assert property ($changed(energy_level) |-> $past(sample_out_valid))
        else $error("energy moved off sample timing");
endmodule
bind dac_volume_front dac_volume_front_props u_props (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .hwrite(hwrite), .htrans(htrans), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sample_valid(sample_valid),
    .sample_out(sample_out), .sample_out_valid(sample_out_valid),
    .interp_filter_sel(interp_filter_sel), .energy_level(energy_level));

// *** testbench/vol_pin_model.sv ***
`timescale 1ns/1ns
module vol_pin_model (
    input  wire logic [6:0] pin_code,
    input  wire logic [6:0] sar_trial,
    output logic            vol_cmp
);
    // comparator high while the pin level sits at or above the trial code
    assign vol_cmp = (pin_code >= sar_trial);
endmodule

// *** testbench/dac_volume_front_tb.sv ***
`timescale 1ns/1ns
`include "dac_vol_defines.svh"
module dac_volume_front_tb;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [11:0] haddr;
    logic        hwrite;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [15:0] sample_in;
    logic        sample_valid;
    logic [15:0] sample_out;
    logic        sample_out_valid;
    logic        vol_cmp;
    logic [6:0]  sar_trial;
    logic [6:0]  pin_code;
    logic [1:0]  interp_filter_sel;
    logic [15:0] energy_level;
    int          errors;
    int          checks;
    int          act;
    logic [15:0] x;
    logic [15:0] y;
    logic [31:0] rd;
    logic [7:0]  pin_tab [3];
    dac_volume_front #(.SAR_DIV_INT(2), .SAR_DIV_EXT(3), .UPDATE_BASE(1)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .hwrite(hwrite),
        .htrans(htrans), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .sample_in(sample_in),
        .sample_valid(sample_valid), .sample_out(sample_out),
        .sample_out_valid(sample_out_valid), .vol_cmp(vol_cmp), .sar_trial(sar_trial),
        .interp_filter_sel(interp_filter_sel), .energy_level(energy_level));
    vol_pin_model pin (.pin_code(pin_code), .sar_trial(sar_trial), .vol_cmp(vol_cmp));
    // core clock never stops, so every ramp can finish
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    task automatic close_out();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // single transfer, each phase held until hready is seen high
    task automatic bus(input logic [9:0] idx, input logic w, input logic [7:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {idx, 2'b00};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rchk(input logic [9:0] idx, input logic [31:0] exp, input string what);
        bus(idx, 1'b0, 8'h00);
        chk(rd, exp, what);
    endtask
    // one sample, then the spacing the energy chain needs
    task automatic smp(input logic [15:0] xi);
        @(posedge hclk);
        sample_valid <= 1'b1;
        sample_in <= xi;
        @(posedge hclk);
        sample_valid <= 1'b0;
        #1;
        chk(sample_out_valid, 1'b1, "valid");
        y = sample_out;
        repeat (3) @(posedge hclk);
    endtask
    initial begin
        #600000;
        errors++;
        close_out();
    end
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 12'h000;
        hwrite = 1'b0;
        htrans = 2'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        sample_in = 16'h0;
        sample_valid = 1'b0;
        pin_code = 7'h00;
        pin_tab = '{8'h28, 8'h64, 8'h7f};
        void'($urandom(32'h8b62282b));
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        // reset values, unmapped place, coefficient bytes
        rchk(`IDX_FLAGS, 32'h10, "flags");
        rchk(`IDX_MUTE_CTRL, 32'h02, "mute");
        rchk(`IDX_PIN_GAIN, 32'h0, "pin gain");
        bus(10'h3ff, 1'b1, 8'h5a);
        rchk(10'h3ff, 32'h0, "unmapped");
        for (int k = 0; k < 12; k++) begin
            rchk(`IDX_COEF_LO + 10'(k), 32'(8'(`COEF_RESET >> (88 - 8 * k))), "coef");
        end
        for (int m = 0; m < 4; m++) begin
            bus(`IDX_RATE, 1'b1, 8'(m));
            repeat (2) @(posedge hclk);
            #1;
            chk(interp_filter_sel, (m > 2) ? 2'h2 : 2'(m), "filter");
        end
        $display("test registers done");
        // one eighth per sample up to +1 dB, then half rate back down
        bus(`IDX_GAIN, 1'b1, 8'h02);
        act = 0;
        rchk(`IDX_FLAGS, 32'h0, "busy");
        for (int i = 0; i < 8; i++) begin
            smp(16'h0100);
            act++;
            rchk(`IDX_FLAGS, (act == 8) ? 32'h10 : 32'h0, "step flag");
        end
        bus(`IDX_STEP_CTRL, 1'b1, 8'h01);
        bus(`IDX_GAIN, 1'b1, 8'h00);
        repeat (8) smp(16'h0100);
        rchk(`IDX_FLAGS, 32'h0, "half busy");
        repeat (8) smp(16'h0100);
        rchk(`IDX_FLAGS, 32'h10, "half done");
        $display("test stepping done");
        // stepping off, master enable toggled, then mute
        bus(`IDX_STEP_CTRL, 1'b1, 8'h02);
        bus(`IDX_GAIN, 1'b1, 8'h0c);
        rchk(`IDX_FLAGS, 32'h10, "off done");
        for (int i = 0; i < 4; i++) begin
            x = 16'($urandom_range(0, 16'h3fff));
            bus(`IDX_MUTE_CTRL, 1'b1, i[0] ? 8'h00 : 8'h02);
            smp(x);
            chk(y, i[0] ? x : 16'(x * 2), "gain");
        end
        bus(`IDX_MUTE_CTRL, 1'b1, 8'h0a);
        smp(16'h4000);
        smp(16'h4000);
        chk(y, 16'h0, "muted");
        bus(`IDX_MUTE_CTRL, 1'b1, 8'h02);
        bus(`IDX_GAIN, 1'b1, 8'h00);
        // pass-through estimator so the detector sees the output level
        for (int k = 0; k < 12; k++) begin
            bus(`IDX_COEF_LO + 10'(k), 1'b1,
                (k % 6 == 0) ? 8'h7f : ((k % 6 == 1) ? 8'hff : 8'h00));
        end
        // compressor cuts loud samples, none when disabled
        bus(`IDX_DRC_CTRL, 1'b1, 8'h20);
        repeat (12) smp(16'h6000);
        chk(y < 16'h6000, 1'b1, "cut");
        chk(energy_level > 16'h4000, 1'b1, "energy");
        bus(`IDX_DRC_CTRL, 1'b1, 8'h00);
        smp(16'h6000);
        chk(y, 16'h6000, "drc off");
        $display("test gain done");
        // pin converter codes: half-dB, one-dB and mute regions
        for (int i = 0; i < 3; i++) begin
            pin_code <= pin_tab[i][6:0];
            bus(`IDX_PIN_CTRL, 1'b1, 8'h80 | 8'(i << 6) | 8'(i));
            rd = 32'h0;
            for (int n = 0; n < 100 && rd !== 32'(pin_tab[i]); n++) bus(`IDX_PIN_GAIN, 1'b0, 8'h0);
            chk(rd, 32'(pin_tab[i]), "pin gain");
            x = (i == 0) ? 16'h00fc : ((i == 1) ? 16'h00b6 : 16'h0081);
            rchk(`IDX_GAIN, 32'(x), "pin map");
        end
        bus(`IDX_PIN_CTRL, 1'b1, 8'h00);
        pin_code <= 7'h0a;
        bus(`IDX_GAIN, 1'b1, 8'h10);
        repeat (200) @(posedge hclk);
        rchk(`IDX_GAIN, 32'h10, "reg source");
        rchk(`IDX_PIN_GAIN, 32'h7f, "pin kept");
        $display("test pin done");
        close_out();
    end
endmodule
